//--- rtl/tmac_pkg.sv
package tmac_pkg;

  // Clock
  localparam int unsigned CLK_MHZ          = 250;

  // Thresholds: six warnings plus shutdown
  localparam int unsigned NUM_WARN         = 6;
  localparam int unsigned NUM_CMP          = NUM_WARN + 1;
  localparam int unsigned SD_IDX           = NUM_WARN;

  // Debounce, 10 us
  localparam int unsigned DEBOUNCE_US      = 10;
  localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned DB_W             = 12;

  // Sampling window 450 us every 3.0 ms (3000 us)
  localparam int unsigned SAMPLE_WIN_US    = 450;
  localparam int unsigned SAMPLE_INT_US    = 3000;
  localparam int unsigned SAMPLE_WIN_CYC   = SAMPLE_WIN_US * CLK_MHZ;
  localparam int unsigned SAMPLE_INT_CYC   = SAMPLE_INT_US * CLK_MHZ;
  localparam int unsigned SMP_W            = 20;

  // Register offsets
  localparam logic [3:0] REG_IRQ_FLAG      = 4'h0;
  localparam logic [3:0] REG_SENSE         = 4'h1;
  localparam logic [3:0] REG_IRQ_MASK      = 4'h2;
  localparam logic [3:0] REG_MON_CTRL      = 4'h3;
  localparam logic [3:0] REG_ANALOG_SELECTOR_CTRL     = 4'h4;
  localparam logic [3:0] REG_STATUS        = 4'h5;

  // Field positions
  localparam int unsigned MON_EN_BIT       = 0;
  localparam int unsigned MON_AON_BIT      = 1;
  localparam int unsigned ANALOG_MUX_ENABLE_BIT      = 5;
  localparam int unsigned ST_SD_BIT        = 0;
  localparam int unsigned ST_PWR_BIT       = 1;
  localparam int unsigned ST_ON_BIT        = 2;

  // Reset values
  localparam logic [5:0] MASK_RST         = 6'h3f;
  localparam logic [1:0] MON_CTRL_RST     = 2'h3;

  // Selector codes
  localparam logic [4:0] SEL_HIGH_Z       = 5'h00;
  localparam logic [4:0] SEL_DIE_TEMP     = 5'h07;

  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_STANDBY,
    PWR_RUN
  } tmac_pwr_t;

  typedef struct packed {
    logic       pin_drive_en;
    logic       power_good_en;
    logic       high_z;
    logic       die_temperature_channel;
  } tmac_analog_selector_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmac_bus_t;

endpackage

//--- rtl/tmac_debounce.sv
`timescale 1ns/10ps
module tmac_debounce
  import tmac_pkg::*;
(
  // Clock and control
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  input  wire logic i_ce,
  input  wire logic i_eval,
  // Raw comparator and filtered result
  input  wire logic i_raw,
  output logic      o_level
);

  logic [DB_W-1:0] count;

  // Holds value while not evaluating, so sampled mode keeps the last result
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      count   <= '0;
      o_level <= 1'b0;
    end
    else if (i_ce && i_eval)
    begin
      if (i_raw == o_level)
        count <= '0;
      else if (count == DB_W'(DEBOUNCE_CYC - 1))
      begin
        count   <= '0;
        o_level <= i_raw;
      end
      else
        count <= count + 1'b1;
    end
  end

endmodule

//--- rtl/tmac_sampler.sv
`timescale 1ns/10ps
module tmac_sampler
  import tmac_pkg::*;
(
  // Clock and control
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  input  wire logic i_ce,
  input  wire logic i_run,
  // Window active
  output logic      o_window
);

  logic [SMP_W-1:0] count;

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      count <= '0;
    else if (i_ce)
    begin
      if (!i_run || count == SMP_W'(SAMPLE_INT_CYC - 1))
        count <= '0;
      else
        count <= count + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_window <= 1'b0;
    else if (i_ce)
      o_window <= i_run && (count < SMP_W'(SAMPLE_WIN_CYC));
  end

endmodule

//--- rtl/tmac_top.sv
// Notes on behaviour
// - Six warning thresholds, each with irq flag, sense flag and mask.
// - A debounced threshold crossing sets that threshold's irq flag.
// - Every comparator passes a 10 us debounce on both edges.
// - Sense releases only below the 5 C hysteresis comparator.
// - Shutdown at 165 C, restart blocked until below shutdown hysteresis.
// - Monitor enable 0 disables monitoring, 1 enables it.
// - Run with always-on set keeps sensor powered continuously.
// - Always-on clear: sensor powered 450 us every 3.0 ms.
// - Standby: sampling only, only with monitor enabled, ignores always-on.
// - Mux enable 0 gives pin to power-good; 1 gives it to the mux.
// - Select 00000 high impedance, 00111 die temperature, others reserved.
// - Mux operates and selects only in On states.
`timescale 1ns/10ps
module tmac_top
  import tmac_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                i_core_clk,
  input  wire logic                i_srst,
  input  wire logic                i_ce,
  // Register port
  input  wire logic [3:0]          i_addr,
  input  wire logic [7:0]          i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [7:0]          o_rdata,
  // Power state from the system sequencer
  input  wire logic [1:0]          i_pwr_state,
  // Comparators: assert-point and release-point per warning
  input  wire logic [NUM_WARN-1:0] i_warn_trip,
  input  wire logic [NUM_WARN-1:0] i_warn_release_n,
  input  wire logic                i_sd_trip,
  input  wire logic                i_sd_release_n,
  // Sensor and shutdown
  output logic                     o_sensor_power,
  output logic                     o_thermal_shutdown,
  output logic                     o_restart_block,
  output logic                     o_irq,
  // Analog selector control
  output tmac_analog_selector_t               o_analog_selector
);

  tmac_bus_t             bus;
  tmac_pwr_t             pwr;
  logic [NUM_WARN-1:0]   temp_threshold_irq_flag;
  logic [NUM_WARN-1:0]   temp_threshold_sense_flag;
  logic [NUM_WARN-1:0]   temp_threshold_irq_mask;
  logic                  temp_monitor_enable;
  logic                  temp_monitor_always_on;
  logic                  analog_mux_enable;
  logic [4:0]            analog_mux_channel_select;
  logic [NUM_CMP-1:0]    trip_db;
  logic [NUM_CMP-1:0]    rel_db;
  logic [NUM_CMP-1:0]    raw_trip;
  logic [NUM_CMP-1:0]    raw_rel;
  logic [NUM_WARN-1:0]   sense_prev;
  logic                  sampling_run;
  logic                  window;
  logic                  eval;
  logic                  sys_on;
  logic                  next_sensor_power;

  assign bus.addr  = i_addr;
  assign bus.wdata = i_wdata;
  assign bus.wr    = i_wr;
  assign bus.rd    = i_rd;
  assign pwr       = tmac_pwr_t'(i_pwr_state);
  assign raw_trip  = {i_sd_trip, i_warn_trip};
  assign raw_rel   = ~{i_sd_release_n, i_warn_release_n};
  assign sys_on    = (pwr == PWR_RUN) || (pwr == PWR_STANDBY);

  // Sensor power policy per power state
  always_comb
  begin
    sampling_run = 1'b0;
    next_sensor_power = 1'b0;
    case (pwr)
      PWR_RUN:
      begin
        if (temp_monitor_enable)
        begin
          sampling_run = !temp_monitor_always_on;
          next_sensor_power = temp_monitor_always_on
                              || window;
        end
      end
      PWR_STANDBY:
      begin
        sampling_run = temp_monitor_enable;
        next_sensor_power = temp_monitor_enable && window;
      end
      default:
      begin
        sampling_run = 1'b0;
        next_sensor_power = 1'b0;
      end
    endcase
  end

  tmac_sampler u_sampler (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_ce       (i_ce),
    .i_run      (sampling_run),
    .o_window   (window)
  );

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_sensor_power <= 1'b0;
    else if (i_ce)
      o_sensor_power <= next_sensor_power;
  end

  // Comparators only trusted once the sensor has had a powered cycle
  assign eval = o_sensor_power && next_sensor_power;

  // Both the trip and release comparators get the same filter
  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g = g + 1)
    begin : g_cmp
      tmac_debounce u_trip (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_ce       (i_ce),
        .i_eval     (eval),
        .i_raw      (raw_trip[g]),
        .o_level    (trip_db[g])
      );
      tmac_debounce u_rel (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_ce       (i_ce),
        .i_eval     (eval),
        .i_raw      (raw_rel[g]),
        .o_level    (rel_db[g])
      );
    end
  endgenerate

  // Sense with hysteresis; it freezes outside windows
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      temp_threshold_sense_flag <= '0;
    else if (i_ce && eval)
    begin
      for (int i = 0; i < NUM_WARN; i++)
      begin
        if (trip_db[i])
          temp_threshold_sense_flag[i] <= 1'b1;
        else if (rel_db[i])
          temp_threshold_sense_flag[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      sense_prev <= '0;
    else if (i_ce)
      sense_prev <= temp_threshold_sense_flag;
  end

  // Write-one-to-clear; a new crossing in the same cycle wins
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      temp_threshold_irq_flag <= '0;
    else if (i_ce)
    begin
      for (int i = 0; i < NUM_WARN; i++)
      begin
        if (temp_threshold_sense_flag[i] && !sense_prev[i])
          temp_threshold_irq_flag[i] <= 1'b1;
        else if (bus.wr && bus.addr == REG_IRQ_FLAG && bus.wdata[i])
          temp_threshold_irq_flag[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_irq <= 1'b0;
    else if (i_ce)
      o_irq <= |(temp_threshold_irq_flag & ~temp_threshold_irq_mask);
  end

  // Restart block latches until the cooled release point is seen; shutdown clears once the trip filter drops
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_thermal_shutdown <= 1'b0;
      o_restart_block    <= 1'b0;
    end
    else if (i_ce)
    begin
      if (trip_db[SD_IDX] && sys_on)
      begin
        o_thermal_shutdown <= 1'b1;
        o_restart_block    <= 1'b1;
      end
      else
      begin
        o_thermal_shutdown <= 1'b0;
        if (rel_db[SD_IDX])
          o_restart_block <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      temp_threshold_irq_mask   <= MASK_RST;
      temp_monitor_enable       <= MON_CTRL_RST[MON_EN_BIT];
      temp_monitor_always_on    <= MON_CTRL_RST[MON_AON_BIT];
      analog_mux_enable         <= 1'b0;
      analog_mux_channel_select <= SEL_HIGH_Z;
    end
    else if (i_ce && bus.wr)
    begin
      if (bus.addr == REG_IRQ_MASK)
        temp_threshold_irq_mask <= bus.wdata[NUM_WARN-1:0];
      else if (bus.addr == REG_MON_CTRL)
      begin
        temp_monitor_enable    <= bus.wdata[MON_EN_BIT];
        temp_monitor_always_on <= bus.wdata[MON_AON_BIT];
      end
      else if (bus.addr == REG_ANALOG_SELECTOR_CTRL)
      begin
        analog_mux_enable         <= bus.wdata[ANALOG_MUX_ENABLE_BIT];
        analog_mux_channel_select <= bus.wdata[4:0];
      end
    end
  end

  // Selector drive; reserved codes leave the buffer off
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_analog_selector <= '{pin_drive_en: 1'b0, power_good_en: 1'b1,
                  high_z: 1'b1, die_temperature_channel: 1'b0};
    else if (i_ce)
    begin
      o_analog_selector.power_good_en <= !analog_mux_enable;
      if (analog_mux_enable && sys_on)
      begin
        o_analog_selector.high_z <=
          (analog_mux_channel_select != SEL_DIE_TEMP);
        o_analog_selector.die_temperature_channel <=
          (analog_mux_channel_select == SEL_DIE_TEMP);
        o_analog_selector.pin_drive_en <=
          (analog_mux_channel_select == SEL_DIE_TEMP);
      end
      else
      begin
        o_analog_selector.high_z                  <= 1'b1;
        o_analog_selector.die_temperature_channel <= 1'b0;
        o_analog_selector.pin_drive_en            <= 1'b0;
      end
    end
  end

  // Read port, data valid the cycle after the strobe
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_rdata <= '0;
    else if (i_ce)
    begin
      if (!bus.rd)
        o_rdata <= '0;
      else if (bus.addr == REG_IRQ_FLAG)
        o_rdata <= {2'h0, temp_threshold_irq_flag};
      else if (bus.addr == REG_SENSE)
        o_rdata <= {2'h0, temp_threshold_sense_flag};
      else if (bus.addr == REG_IRQ_MASK)
        o_rdata <= {2'h0, temp_threshold_irq_mask};
      else if (bus.addr == REG_MON_CTRL)
        o_rdata <= {6'h00, temp_monitor_always_on, temp_monitor_enable};
      else if (bus.addr == REG_ANALOG_SELECTOR_CTRL)
        o_rdata <= {2'h0, analog_mux_enable, analog_mux_channel_select};
      else if (bus.addr == REG_STATUS)
        o_rdata <= {5'h00, sys_on, o_sensor_power, o_restart_block};
      else
        o_rdata <= '0;
    end
  end

endmodule

//--- bench/tmac_sensor_model.sv
`timescale 1ns/10ps
module tmac_sensor_model
  import tmac_pkg::*;
(
  // Die temperature, whole degrees
  input  wire logic [7:0]          i_temp,
  // Comparator outputs
  output logic      [NUM_WARN-1:0] o_trip,
  output logic      [NUM_WARN-1:0] o_rel_n,
  output logic                     o_sd_trip,
  output logic                     o_sd_rel_n
);
  localparam logic [7:0] BASE = 8'h50;
  localparam logic [7:0] STEP = 8'h0f;
  localparam logic [7:0] HYS  = 8'h05;
  localparam logic [7:0] SD   = 8'ha5;
  // Either hysteresis figure may hold; the smaller one is the harder case
  localparam logic [7:0] SDH  = 8'h0a;

  always_comb
  begin
    for (int k = 0; k < NUM_WARN; k++)
    begin
      o_trip[k]  = i_temp > BASE + STEP * k;
      o_rel_n[k] = i_temp >= BASE + STEP * k - HYS;
    end
    o_sd_trip  = i_temp > SD;
    o_sd_rel_n = i_temp >= SD - SDH;
  end
endmodule

//--- bench/tmac_top_sva.sv
`timescale 1ns/10ps
module tmac_chk
  import tmac_pkg::*;
(
  input wire logic       i_core_clk,
  input wire logic       i_srst,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] i_pwr_state,
  input wire logic       i_sd_trip,
  input wire logic       i_sd_release_n,
  input wire logic       o_sensor_power,
  input wire logic       o_thermal_shutdown,
  input wire logic       o_restart_block,
  input tmac_analog_selector_t      o_analog_selector
);
  logic [11:0] trip_run;
  logic [11:0] rel_run;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  // Saturating runs of a steady comparator level
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || !i_sd_trip)
      trip_run <= 12'h000;
    else if (trip_run != 12'hfff)
      trip_run <= trip_run + 12'h001;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || i_sd_release_n)
      rel_run <= 12'h000;
    else if (rel_run != 12'hfff)
      rel_run <= rel_run + 12'h001;
  end

  a_rdata_idle: assert property (
    !i_rd |=> o_rdata == 8'h00) else $error("read data not zero");
  a_pgood_excl: assert property (
    o_analog_selector.pin_drive_en |-> !o_analog_selector.power_good_en) else $error("pin shared");
  a_drive_on_state: assert property (
    o_analog_selector.pin_drive_en |-> $past(i_pwr_state) inside {2'h1, 2'h2})
    else $error("selector driven outside on states");
  a_temp_drive: assert property (
    o_analog_selector.die_temperature_channel |-> o_analog_selector.pin_drive_en && !o_analog_selector.high_z)
    else $error("channel without drive");
  a_off_no_sensor: assert property (
    i_pwr_state == 2'h0 |=> !o_sensor_power) else $error("sensor on in off");
  a_sd_sets_block: assert property (
    $rose(o_thermal_shutdown) |-> o_restart_block) else $error("no block");
  a_sd_debounce: assert property (
    $rose(o_thermal_shutdown) |-> trip_run >= 12'h9c3)
    else $error("shutdown before debounce");
  a_block_hold: assert property (
    o_restart_block && i_sd_release_n && $past(i_sd_release_n, 3)
    |=> o_restart_block) else $error("block dropped while hot");
  a_rel_debounce: assert property (
    $fell(o_restart_block) |-> $past(rel_run, 2) >= 12'h9c2)
    else $error("block released before debounce");
endmodule

bind tmac_top tmac_chk chk_u (.i_core_clk, .i_srst, .i_rd, .o_rdata,
  .i_pwr_state, .i_sd_trip, .i_sd_release_n, .o_sensor_power,
  .o_thermal_shutdown, .o_restart_block, .o_analog_selector);

//--- bench/tb_thermal_monitor_analog_selector_control.sv
`timescale 1ns/10ps
module tb_thermal_monitor_analog_selector_control
  import tmac_pkg::*;
;
  logic                i_core_clk;
  logic                i_srst;
  logic                i_ce;
  logic [3:0]          i_addr;
  logic [7:0]          i_wdata;
  logic                i_wr;
  logic                i_rd;
  logic [1:0]          i_pwr_state;
  logic [7:0]          temp;
  logic [7:0]          o_rdata;
  logic [NUM_WARN-1:0] trip;
  logic [NUM_WARN-1:0] rel_n;
  logic                sd_trip;
  logic                sd_rel_n;
  logic                o_sensor_power;
  logic                o_thermal_shutdown;
  logic                o_restart_block;
  logic                o_irq;
  tmac_analog_selector_t          o_analog_selector;
  int                  miscompares;
  int                  checked;
  logic                rd_pend;
  logic [7:0]          exp_q[$];
  logic [4:0]          sel;
  logic                en;
  logic                drv;
  logic [1:0]          st;

  tmac_top dut_u (.i_core_clk, .i_srst, .i_ce, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_pwr_state, .i_warn_trip(trip),
    .i_warn_release_n(rel_n), .i_sd_trip(sd_trip),
    .i_sd_release_n(sd_rel_n), .o_sensor_power, .o_thermal_shutdown,
    .o_restart_block, .o_irq, .o_analog_selector);
  tmac_sensor_model sens_u (.i_temp(temp), .o_trip(trip), .o_rel_n(rel_n),
    .o_sd_trip(sd_trip), .o_sd_rel_n(sd_rel_n));

  always #2 i_core_clk = ~i_core_clk;

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge i_core_clk)
  begin
    if (rd_pend)
      cmp(o_rdata, exp_q.pop_front());
    rd_pend <= i_rd;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge i_core_clk);
    miscompares++;
    $display("mismatch at %0t: run did not end", $time);
    tally_and_finish();
  end

  initial
  begin
    i_core_clk = 1'b0;
    i_srst = 1'b1;
    i_ce = 1'b1;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_pwr_state = 2'h2;
    temp = 8'h19;
    rd_pend = 1'b0;
    void'($urandom(14490));
    hold(5);
    i_srst <= 1'b0;
    rd(4'h2, 8'h3f);
    rd(4'h3, 8'h03);
    rd(4'h4, 8'h00);
    rd(4'h0, 8'h00);
    rd(4'h6, 8'h00);
    rd(4'h5, 8'h06);
    cmp({4'h0, o_analog_selector}, 8'h06);
    $display("test reset done");
    temp <= 8'h64;
    hold(2600);
    rd(4'h1, 8'h03);
    rd(4'h0, 8'h03);
    cmp({7'h00, o_irq}, 8'h00);
    wr(4'h2, 8'h3c);
    hold(3);
    cmp({7'h00, o_irq}, 8'h01);
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h02);
    wr(4'h0, 8'h02);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h03);
    hold(3);
    cmp({7'h00, o_irq}, 8'h00);
    $display("test warning flags done");
    temp <= 8'h5c;
    hold(2600);
    rd(4'h1, 8'h03);
    temp <= 8'h78;
    hold(100);
    temp <= 8'h58;
    hold(2600);
    rd(4'h1, 8'h01);
    rd(4'h0, 8'h00);
    $display("test hysteresis done");
    temp <= 8'haa;
    hold(2600);
    cmp({6'h00, o_thermal_shutdown, o_restart_block}, 8'h03);
    rd(4'h5, 8'h07);
    temp <= 8'ha0;
    hold(2600);
    cmp({6'h00, o_thermal_shutdown, o_restart_block}, 8'h01);
    temp <= 8'h64;
    hold(2600);
    cmp({6'h00, o_thermal_shutdown, o_restart_block}, 8'h00);
    $display("test shutdown done");
    wr(4'h3, 8'h00);
    hold(3);
    cmp({7'h00, o_sensor_power}, 8'h00);
    i_pwr_state <= 2'h1;
    wr(4'h3, 8'h02);
    hold(3);
    cmp({7'h00, o_sensor_power}, 8'h00);
    i_pwr_state <= 2'h2;
    wr(4'h3, 8'h03);
    hold(3);
    cmp({7'h00, o_sensor_power}, 8'h01);
    $display("test sensor power done");
    // Enable low must freeze the filters, so a cool die is never seen
    i_ce <= 1'b0;
    temp <= 8'h19;
    hold(3000);
    i_ce <= 1'b1;
    rd(4'h1, 8'h03);
    $display("test clock enable done");
    // First three cases fix select 7 and 0 in Run, Off and Standby
    for (int n = 0; n < 14; n++)
    begin
      sel = (n < 3) ? ((n == 2) ? 5'h00 : 5'h07) : 5'($urandom % 32);
      en = (n < 3) ? 1'b1 : 1'($urandom % 2);
      st = (n < 3) ? {n == 0, n == 2} : 2'($urandom % 4);
      i_pwr_state <= st;
      wr(4'h4, {2'h0, en, sel});
      hold(3);
      drv = en && (st == 2'h1 || st == 2'h2) && sel == 5'h07;
      cmp({4'h0, o_analog_selector}, {4'h0, drv, !en, !drv, drv});
      rd(4'h4, {2'h0, en, sel});
    end
    $display("test selector done");
    hold(3);
    tally_and_finish();
  end
endmodule
